// ---- hdl/cdbg_top.sv ----
// cdbg_top: dead-band insertion for a complementary drive pair
`timescale 1ns/10ps
// Operation
// - two independent 7-bit dead-band counters, one per edge direction.
// - dead band counts unit clock periods from zero up to the setting.
// - input rise turns second output off at once and starts rising count.
// - rising count reaching its setting turns the first output on.
// - rising delay setting gives rising dead band, 0 through 64.
// - a setting of zero turns the opposite output on with no gap.
// - timing always starts from the input edge, never from outputs.
// - input returning early means the pending output never turns on.
// - input fall turns first output off, counts, then second output on.
// - falling delay setting gives falling dead band, 0 through 64.
module cdbg_top
  import cdbg_pkg::*;
#(
  parameter int unsigned CLK_DIV = CDBG_DIV_DEF
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // input source, from a pin
  input wire logic src_in,
  // delay settings, static configuration
  input wire cdbg_delay_s delay_cfg,
  // drive outputs to the power switch gate drivers
  output cdbg_drive_s drive_out
);

  localparam logic [CDBG_DIV_W-1:0] DIV_LAST =
    CDBG_DIV_W'(CLK_DIV - 1);

  // both outputs off, the safe level after reset
  localparam cdbg_drive_s DRIVE_OFF = '{
    first_drive_output: CDBG_OFF,
    second_drive_output: CDBG_OFF
  };

  // level change tests on the settled input source
  function automatic logic cdbg_rose(
    input logic cur,
    input logic prev
  );
    cdbg_rose = cur && !prev;
  endfunction : cdbg_rose

  function automatic logic cdbg_fell(
    input logic cur,
    input logic prev
  );
    cdbg_fell = !cur && prev;
  endfunction : cdbg_fell

  // a zero setting means no dead band at all
  function automatic logic cdbg_no_gap(input cdbg_set_t lim);
    cdbg_no_gap = (lim == CDBG_CNT_RST);
  endfunction : cdbg_no_gap

  // state entered on an edge: straight to on, or into the wait
  function automatic cdbg_state_e cdbg_edge_state(
    input cdbg_set_t lim,
    input cdbg_state_e on_st,
    input cdbg_state_e wait_st
  );
    cdbg_edge_state = cdbg_no_gap(lim) ? on_st : wait_st;
  endfunction : cdbg_edge_state

  // drive pair from the two levels
  function automatic cdbg_drive_s cdbg_pair(
    input logic first,
    input logic second
  );
    cdbg_pair = '{first_drive_output: first,
                  second_drive_output: second};
  endfunction : cdbg_pair

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic src_prev;
    logic [CDBG_DIV_W-1:0] div;
    cdbg_state_e state;
    cdbg_drive_s drive;
  } cdbg_top_s;

  // whole state after reset: input seen low, divider at zero, both off
  localparam cdbg_top_s ST_RST = '{
    sync1: 1'b0,
    sync2: 1'b0,
    src_prev: 1'b0,
    div: CDBG_DIV_RST,
    state: CDBG_ST_IDLE,
    drive: DRIVE_OFF
  };

  cdbg_top_s st_ff;
  cdbg_top_s nxt_st;

  logic rise_edge;
  logic fall_edge;
  logic tick;
  logic rise_done;
  logic fall_done;
  cdbg_set_t rise_lim;
  cdbg_set_t fall_lim;
  logic rise_run;
  logic fall_run;

  // edges of the synchronised input source
  assign rise_edge = cdbg_rose(st_ff.sync2, st_ff.src_prev);
  assign fall_edge = cdbg_fell(st_ff.sync2, st_ff.src_prev);
  // unit clock tick from the divider
  assign tick = (st_ff.div == DIV_LAST);
  assign rise_lim = cdbg_clamp(delay_cfg.rising_delay_setting);
  assign fall_lim = cdbg_clamp(delay_cfg.falling_delay_setting);
  assign drive_out = st_ff.drive;
  // each counter only runs while its own dead band is pending
  assign rise_run = (st_ff.state == CDBG_ST_RISE_WAIT);
  assign fall_run = (st_ff.state == CDBG_ST_FALL_WAIT);

  // rising and falling counters, independent of each other
  cdbg_dead_counter u_rise_cnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(rise_edge),
    .run(rise_run),
    .tick(tick),
    .limit(rise_lim),
    .done(rise_done)
  );

  cdbg_dead_counter u_fall_cnt (
    .sys_clk(sys_clk),
    .rst(rst),
    .clr(fall_edge),
    .run(fall_run),
    .tick(tick),
    .limit(fall_lim),
    .done(fall_done)
  );

  // next value of the whole block state
  always_comb begin
    nxt_st = st_ff;

    // two flops against metastability, then the edge history
    nxt_st.sync1 = src_in;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.src_prev = st_ff.sync2;

    // free-running divider makes the unit clock tick
    if (tick) begin
      nxt_st.div = CDBG_DIV_RST;
    end else begin
      nxt_st.div = CDBG_DIV_W'(st_ff.div + CDBG_DIV_ONE);
    end

    if (rise_edge) begin
      // new edge overrides any pending fall
      nxt_st.drive.second_drive_output = CDBG_OFF;
      nxt_st.state = cdbg_edge_state(rise_lim, CDBG_ST_FIRST_ON,
                                     CDBG_ST_RISE_WAIT);
      if (cdbg_no_gap(rise_lim)) begin
        nxt_st.drive.first_drive_output = CDBG_ON;
      end else begin
        nxt_st.drive.first_drive_output = CDBG_OFF;
      end
    end else if (fall_edge) begin
      nxt_st.drive.first_drive_output = CDBG_OFF;
      nxt_st.state = cdbg_edge_state(fall_lim, CDBG_ST_SECOND_ON,
                                     CDBG_ST_FALL_WAIT);
      if (cdbg_no_gap(fall_lim)) begin
        nxt_st.drive.second_drive_output = CDBG_ON;
      end else begin
        nxt_st.drive.second_drive_output = CDBG_OFF;
      end
    end else begin
      case (st_ff.state)
        CDBG_ST_RISE_WAIT: begin
          if (rise_done) begin
            nxt_st.drive.first_drive_output = CDBG_ON;
            nxt_st.state = CDBG_ST_FIRST_ON;
          end else begin
            nxt_st.drive = DRIVE_OFF;
          end
        end
        CDBG_ST_FALL_WAIT: begin
          if (fall_done) begin
            nxt_st.drive.second_drive_output = CDBG_ON;
            nxt_st.state = CDBG_ST_SECOND_ON;
          end else begin
            nxt_st.drive = DRIVE_OFF;
          end
        end
        CDBG_ST_IDLE: begin
          // both off after reset until the first edge
          nxt_st.drive = DRIVE_OFF;
          nxt_st.state = CDBG_ST_IDLE;
        end
        CDBG_ST_FIRST_ON: begin
          // first holds until the next fall
          nxt_st.drive = cdbg_pair(CDBG_ON, CDBG_OFF);
          nxt_st.state = CDBG_ST_FIRST_ON;
        end
        CDBG_ST_SECOND_ON: begin
          nxt_st.drive = cdbg_pair(CDBG_OFF, CDBG_ON);
          nxt_st.state = CDBG_ST_SECOND_ON;
        end
        default: begin
          nxt_st.state = CDBG_ST_IDLE;
          nxt_st.drive = DRIVE_OFF;
        end
      endcase
    end
  end

  // one register for all state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : cdbg_top

// ---- hdl/cdbg_pkg.sv ----
// cdbg_pkg: shared constants and types of the dead-band generator
package cdbg_pkg;

  // setting and counter width: 6-bit count plus one bit to reach 64
  localparam int unsigned CDBG_SET_W = 7;
  localparam logic [CDBG_SET_W-1:0] CDBG_SET_MAX = 7'h40;
  localparam logic [CDBG_SET_W-1:0] CDBG_CNT_RST = 7'h00;
  localparam logic [CDBG_SET_W-1:0] CDBG_CNT_ONE = 7'h01;

  // unit clock divider default: one tick every sys_clk cycle
  localparam int unsigned CDBG_DIV_DEF = 1;
  localparam int unsigned CDBG_DIV_W = 8;
  localparam logic [CDBG_DIV_W-1:0] CDBG_DIV_RST = 8'h00;
  localparam logic [CDBG_DIV_W-1:0] CDBG_DIV_ONE = 8'h01;

  localparam logic CDBG_OFF = 1'b0;
  localparam logic CDBG_ON = 1'b1;

  typedef logic [CDBG_SET_W-1:0] cdbg_set_t;

  // the complementary drive pair
  typedef struct packed {
    logic first_drive_output;
    logic second_drive_output;
  } cdbg_drive_s;

  // the two delay settings
  typedef struct packed {
    cdbg_set_t rising_delay_setting;
    cdbg_set_t falling_delay_setting;
  } cdbg_delay_s;

  typedef enum logic [4:0] {
    CDBG_ST_IDLE = 5'h01,
    CDBG_ST_RISE_WAIT = 5'h02,
    CDBG_ST_FIRST_ON = 5'h04,
    CDBG_ST_FALL_WAIT = 5'h08,
    CDBG_ST_SECOND_ON = 5'h10
  } cdbg_state_e;

  // limit a setting to the documented top of range
  function automatic cdbg_set_t cdbg_clamp(input cdbg_set_t v);
    cdbg_clamp = (v > CDBG_SET_MAX) ? CDBG_SET_MAX : v;
  endfunction : cdbg_clamp

endpackage : cdbg_pkg

// ---- hdl/cdbg_dead_counter.sv ----
// cdbg_dead_counter: one dead-band counter, counting unit clock ticks
`timescale 1ns/10ps
module cdbg_dead_counter
  import cdbg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic clr,
  input wire logic run,
  input wire logic tick,
  input wire cdbg_set_t limit,
  // result
  output logic done
);

  typedef struct packed {
    cdbg_set_t cnt;
  } cdbg_cnt_s;

  cdbg_cnt_s st_ff;
  cdbg_cnt_s nxt_st;

  // done on the tick that brings the count up to the limit
  assign done = run && tick &&
    (cdbg_set_t'(st_ff.cnt + CDBG_CNT_ONE) == limit);

  always_comb begin
    nxt_st = st_ff;
    if (clr) begin
      nxt_st.cnt = CDBG_CNT_RST;
    end else if (run && tick && !done) begin
      nxt_st.cnt = cdbg_set_t'(st_ff.cnt + CDBG_CNT_ONE);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{cnt: CDBG_CNT_RST};
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : cdbg_dead_counter

// ---- verification/cdbg_top_assertions.sv ----
// checker of the dead-band generator ports
`timescale 1ns/10ps
module cdbg_top_assertions
  import cdbg_pkg::*;
#(parameter int unsigned CLK_DIV = CDBG_DIV_DEF) (
  // watched ports
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic src_in,
  input wire cdbg_delay_s delay_cfg,
  input wire cdbg_drive_s drive_out
);
  logic [3:0] sh_ff;
  logic [7:0] age_ff;
  logic seen_ff;
  logic ev, sn, a, b, hi, rd, fd;
  logic [7:0] age;
  cdbg_set_t r, f;
  assign a = drive_out.first_drive_output;
  assign b = drive_out.second_drive_output;
  assign r = delay_cfg.rising_delay_setting;
  assign f = delay_cfg.falling_delay_setting;
  assign hi = sh_ff[2];
  assign ev = sh_ff[2] ^ sh_ff[3];
  assign sn = seen_ff | ev;
  assign age = ev ? 8'h00 : age_ff + {7'h00, age_ff != 8'hff};
  assign rd = age >= 8'h40 || age >= {1'b0, r};
  assign fd = age >= 8'h40 || age >= {1'b0, f};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sh_ff <= 4'h0;
      age_ff <= 8'h00;
      seen_ff <= 1'b0;
    end else begin
      sh_ff <= {sh_ff[2:0], src_in};
      age_ff <= age;
      seen_ff <= sn;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_no_ovl; !(a && b); endproperty
  a_no_ovl: assert property (p_no_ovl)
    else $error("both outputs on");
  property p_rise_off; $rose(src_in) |-> ##3 !b; endproperty
  a_rise_off: assert property (p_rise_off)
    else $error("second not off");
  property p_fall_off; $fell(src_in) |-> ##3 !a; endproperty
  a_fall_off: assert property (p_fall_off)
    else $error("first not off");
  property p_rise_wait; sn && hi && !rd |-> !a; endproperty
  a_rise_wait: assert property (p_rise_wait)
    else $error("first on early");
  property p_rise_on; sn && hi && rd |-> a; endproperty
  a_rise_on: assert property (p_rise_on)
    else $error("first not on");
  property p_fall_wait; sn && !hi && !fd |-> !b; endproperty
  a_fall_wait: assert property (p_fall_wait)
    else $error("second on early");
  property p_fall_on; sn && !hi && fd |-> b; endproperty
  a_fall_on: assert property (p_fall_on)
    else $error("second not on");
  property p_a_src; $rose(a) |-> $past(src_in, 3); endproperty
  a_a_src: assert property (p_a_src)
    else $error("first on without input");
endmodule : cdbg_top_assertions

// ---- verification/cdbg_gate_model.sv ----
// gate driver pair model that flags shoot-through
`timescale 1ns/10ps
module cdbg_gate_model
  import cdbg_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // drive pair and fault flag
  input wire cdbg_drive_s drive_out,
  output logic shoot_ff
);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      shoot_ff <= 1'b0;
    end else if (&drive_out) begin
      shoot_ff <= 1'b1;
    end
  end
endmodule : cdbg_gate_model

// ---- verification/tb_cdbg_top.sv ----
// testbench of the dead-band generator
`timescale 1ns/10ps
module tb_cdbg_top;
  import cdbg_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic src_in = 1'b0;
  cdbg_delay_s cfg = '0;
  cdbg_drive_s drv;
  logic shoot;
  int num_errors = 0;
  int n_compared = 0;
  cdbg_top i_cdbg_top (.sys_clk(sys_clk), .rst(rst), .src_in(src_in),
    .delay_cfg(cfg), .drive_out(drv));
  cdbg_gate_model i_cdbg_gate_model (.sys_clk(sys_clk), .rst(rst),
    .drive_out(drv), .shoot_ff(shoot));
  initial begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk
  // one input edge, then wait for the opposite output
  task automatic edge_to(input logic lv, input int d);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1 src_in = lv;
    do begin
      @(posedge sys_clk);
      #1 n++;
      if (n == 3) chk(drv[!lv] === 1'b0, "no turn-off");
    end while (drv[lv] !== 1'b1 && n < 200);
    chk(n === d + 3, "dead band length");
  endtask : edge_to
  task automatic t_lengths();
    logic [6:0] v[6] = '{7'h00, 7'h01, 7'h05, 7'h3f, 7'h40, 7'h46};
    foreach (v[i]) begin
      cfg = '{v[i], v[5 - i]};
      edge_to(1'b1, v[i] > 7'h40 ? 64 : v[i]);
      edge_to(1'b0, v[5 - i] > 7'h40 ? 64 : v[5 - i]);
    end
  endtask : t_lengths
  // rise shorter than its dead band, then a fall
  task automatic t_short();
    // let the last dead band age out before the settings move
    repeat (3) @(posedge sys_clk);
    #1 cfg = '{7'h0a, 7'h02};
    @(posedge sys_clk);
    #1 src_in = 1'b1;
    repeat (3) @(posedge sys_clk);
    edge_to(1'b0, 2);
    repeat (15) @(posedge sys_clk);
    chk(drv === 2'b01, "pending turn-on kept");
  endtask : t_short
  task automatic final_report();
    if (num_errors == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (8) @(posedge sys_clk);
    #1 rst = 1'b0;
    t_lengths();
    t_short();
    chk(shoot === 1'b0, "overlap seen");
    final_report();
  end
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule : tb_cdbg_top
bind cdbg_top cdbg_top_assertions #(.CLK_DIV(CLK_DIV)) i_cdbg_top_assertions (
  .sys_clk(sys_clk), .rst(rst), .src_in(src_in), .delay_cfg(delay_cfg),
  .drive_out(drive_out));
